// [src/tlic_defines.vh]
// register offsets, field positions and vectors of the two-level interrupt controller
`ifndef TLIC_DEFINES_VH
`define TLIC_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TLIC_ENABLE0_ADDR 8'ha8
`define TLIC_ENABLE1_ADDR 8'ha9
`define TLIC_LEVEL0_ADDR 8'hb8
`define TLIC_LEVEL1_ADDR 8'hb9
// ----------------------------------------
// writable bit masks and reset values
// ----------------------------------------
`define TLIC_REG0_MASK 8'hfb
`define TLIC_LVL0_MASK 8'h7b
`define TLIC_REG1_MASK 8'h0e
`define TLIC_REG_RESET 8'h00
`define TLIC_GLOBAL_BIT 7
// ----------------------------------------
// per-source field positions
// ----------------------------------------
`define TLIC_EXT0_BIT 0
`define TLIC_TMR0_BIT 1
`define TLIC_TMR1_BIT 3
`define TLIC_SER_BIT 4
`define TLIC_TMR2_BIT 5
`define TLIC_CONV_BIT 6
`define TLIC_PWM_BIT 1
`define TLIC_BTM_BIT 2
`define TLIC_EXT2_BIT 3
// ----------------------------------------
// source index (query order) and vectors
// ----------------------------------------
`define TLIC_NSRC 9
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_TMR0 16'h000b
`define TLIC_VEC_TMR1 16'h001b
`define TLIC_VEC_SER 16'h0023
`define TLIC_VEC_TMR2 16'h002b
`define TLIC_VEC_CONV 16'h0033
`define TLIC_VEC_PWM 16'h0043
`define TLIC_VEC_BTM 16'h004b
`define TLIC_VEC_EXT2 16'h0053
`endif

// [src/tlic_core.v]
// two-level priority interrupt controller with core vectoring handshake
// Summary of operation
// - each source picks high or low level
// - high preempts low, never the reverse
// - same level blocked until return instruction
// - one main instruction after return before accepting
// - same level ties go lowest query number
// - current instruction completes before vectoring
// - vectoring first pushes program counter
// - then load fixed vector into program counter
// - return pops counter and drops active level
// - blocked requests stay pending, served later
// - global gate bit 7 enables all
// - enable register bit map per source
// - converter, timer2, serial enables gate requests
// - level register mirrors enable positions
// - second enable register bits 3..1
// - pwm overflow requests when enabled
// - second level register bits 3..1
// - fixed vectors and query order per source
// - timer0/1 flags cleared on response
// - external groups wake from stop
//
// Our own choice: the address-and-strobe port.
`include "tlic_defines.vh"
module tlic_core (
	input wire clock, // 100 MHz system clock
	input wire rst, // asynchronous reset, active high
	input wire [7:0] reg_addr, // register address
	input wire [7:0] reg_wdata, // register write data
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	output reg [7:0] reg_rdata, // read data, cycle after strobe
	input wire ext_group0, // external group 0 request level
	input wire timer0_overflow_flag, // timer 0 overflow flag
	input wire timer1_overflow_flag, // timer 1 overflow flag
	input wire serial_flag, // serial receive/transmit flag
	input wire timer2_flag, // timer 2 overflow flag
	input wire converter_flag, // conversion complete flag
	input wire pwm_flag, // pwm overflow flag
	input wire base_timer_flag, // base timer overflow flag
	input wire ext_group2, // external group 2 request level
	input wire instr_done, // core finishes an instruction this cycle
	input wire return_from_irq_instr, // core completes return instruction
	input wire [15:0] core_pc, // current program counter
	input wire stack_done, // push or pop finished
	input wire [15:0] pop_pc, // value popped from stack
	output reg push_req, // push push_pc onto stack
	output reg [15:0] push_pc, // return address to save
	output reg pop_req, // pop return address
	output reg pc_load, // one-cycle load of pc_value
	output reg [15:0] pc_value, // vector or restored counter
	output reg [8:0] flag_ack, // per-source response pulse
	output wire timer0_flag_clr, // hardware clear of timer 0 flag
	output wire timer1_flag_clr, // hardware clear of timer 1 flag
	output wire stop_wake // wake from stop
);
	// ----------------------------------------
	// state encoding
	// ----------------------------------------
	localparam S_IDLE = 5'b00001;
	localparam S_PUSH = 5'b00010;
	localparam S_LOAD = 5'b00100;
	localparam S_POP = 5'b01000;
	localparam S_HOLD = 5'b10000;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	reg [7:0] en0_q;
	reg [7:0] en1_q;
	reg [7:0] lvl0_q;
	reg [7:0] lvl1_q;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			en0_q <= `TLIC_REG_RESET;
			en1_q <= `TLIC_REG_RESET;
			lvl0_q <= `TLIC_REG_RESET;
			lvl1_q <= `TLIC_REG_RESET;
		end else if (reg_wr) begin
			// reserved bits ignore writes
			case (reg_addr)
			`TLIC_ENABLE0_ADDR: en0_q <= reg_wdata & `TLIC_REG0_MASK;
			`TLIC_ENABLE1_ADDR: en1_q <= reg_wdata & `TLIC_REG1_MASK;
			`TLIC_LEVEL0_ADDR: lvl0_q <= reg_wdata & `TLIC_LVL0_MASK;
			`TLIC_LEVEL1_ADDR: lvl1_q <= reg_wdata & `TLIC_REG1_MASK;
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// active level state, internal only, not visible on read
	// ----------------------------------------
	reg act_hi_q;
	reg act_lo_q;
	reg [4:0] state_q;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`TLIC_ENABLE0_ADDR: reg_rdata <= en0_q;
			`TLIC_ENABLE1_ADDR: reg_rdata <= en1_q;
			`TLIC_LEVEL0_ADDR: reg_rdata <= lvl0_q;
			`TLIC_LEVEL1_ADDR: reg_rdata <= lvl1_q;
			default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// named control fields
	// ----------------------------------------
	wire global_irq_gate;
	wire ext_group0_irq_en;
	wire timer0_irq_en;
	wire timer1_irq_en;
	wire serial_irq_en;
	wire timer2_irq_en;
	wire converter_irq_en;
	wire pwm_irq_en;
	wire base_timer_irq_en;
	wire ext_group2_irq_en;
	wire ext_group0_irq_level;
	wire timer0_irq_level;
	wire timer1_irq_level;
	wire serial_irq_level;
	wire timer2_irq_level;
	wire converter_irq_level;
	wire pwm_irq_level;
	wire base_timer_irq_level;
	wire ext_group2_irq_level;
	assign global_irq_gate = en0_q[`TLIC_GLOBAL_BIT];
	assign ext_group0_irq_en = en0_q[`TLIC_EXT0_BIT];
	assign timer0_irq_en = en0_q[`TLIC_TMR0_BIT];
	assign timer1_irq_en = en0_q[`TLIC_TMR1_BIT];
	assign serial_irq_en = en0_q[`TLIC_SER_BIT];
	assign timer2_irq_en = en0_q[`TLIC_TMR2_BIT];
	assign converter_irq_en = en0_q[`TLIC_CONV_BIT];
	assign pwm_irq_en = en1_q[`TLIC_PWM_BIT];
	assign base_timer_irq_en = en1_q[`TLIC_BTM_BIT];
	assign ext_group2_irq_en = en1_q[`TLIC_EXT2_BIT];
	assign ext_group0_irq_level = lvl0_q[`TLIC_EXT0_BIT];
	assign timer0_irq_level = lvl0_q[`TLIC_TMR0_BIT];
	assign timer1_irq_level = lvl0_q[`TLIC_TMR1_BIT];
	assign serial_irq_level = lvl0_q[`TLIC_SER_BIT];
	assign timer2_irq_level = lvl0_q[`TLIC_TMR2_BIT];
	assign converter_irq_level = lvl0_q[`TLIC_CONV_BIT];
	assign pwm_irq_level = lvl1_q[`TLIC_PWM_BIT];
	assign base_timer_irq_level = lvl1_q[`TLIC_BTM_BIT];
	assign ext_group2_irq_level = lvl1_q[`TLIC_EXT2_BIT];

	// ----------------------------------------
	// request gating, index is query order
	// ----------------------------------------
	wire [8:0] flags;
	wire [8:0] src_en;
	wire [8:0] src_lvl;
	wire gate;
	wire [8:0] req;
	assign flags = {ext_group2, base_timer_flag, pwm_flag, converter_flag, timer2_flag,
		serial_flag, timer1_overflow_flag, timer0_overflow_flag, ext_group0};
	assign src_en = {ext_group2_irq_en, base_timer_irq_en, pwm_irq_en, converter_irq_en,
		timer2_irq_en, serial_irq_en, timer1_irq_en, timer0_irq_en,
		ext_group0_irq_en};
	assign src_lvl = {ext_group2_irq_level, base_timer_irq_level, pwm_irq_level,
		converter_irq_level, timer2_irq_level, serial_irq_level, timer1_irq_level,
		timer0_irq_level, ext_group0_irq_level};
	assign gate = global_irq_gate;
	// flags are never latched here, so masked ones stay pending at the source
	assign req = flags & src_en & {9{gate}};

	// wake does not need the global gate: stop has no instruction stream
	assign stop_wake = (ext_group0 & ext_group0_irq_en) | (ext_group2 & ext_group2_irq_en);

	// ----------------------------------------
	// winner selection
	// ----------------------------------------
	wire [8:0] req_hi;
	wire [8:0] req_lo;
	wire [8:0] cand;
	reg [3:0] win_idx;
	reg win_ok;
	integer i;
	assign req_hi = req & src_lvl;
	assign req_lo = req & ~src_lvl;
	// high allowed unless a high routine runs; low only when nothing runs
	assign cand = (|req_hi & ~act_hi_q) ? req_hi :
		((~act_hi_q & ~act_lo_q) ? req_lo : 9'h000);
	always @* begin
		win_idx = 4'h0;
		win_ok = 1'b0;
		for (i = `TLIC_NSRC - 1; i >= 0; i = i - 1) begin
			if (cand[i]) begin
				win_idx = i[3:0];
				win_ok = 1'b1;
			end
		end
	end

	function [15:0] vec_of;
		input [3:0] idx;
		begin
			case (idx)
			4'h0: vec_of = `TLIC_VEC_EXT0;
			4'h1: vec_of = `TLIC_VEC_TMR0;
			4'h2: vec_of = `TLIC_VEC_TMR1;
			4'h3: vec_of = `TLIC_VEC_SER;
			4'h4: vec_of = `TLIC_VEC_TMR2;
			4'h5: vec_of = `TLIC_VEC_CONV;
			4'h6: vec_of = `TLIC_VEC_PWM;
			4'h7: vec_of = `TLIC_VEC_BTM;
			default: vec_of = `TLIC_VEC_EXT2;
			endcase
		end
	endfunction

	// ----------------------------------------
	// vectoring and return sequencer
	// ----------------------------------------
	reg [3:0] grant_q;
	reg grant_hi_q;
	// level stack: which level each nested routine runs at
	reg [1:0] nest_q;
	assign timer0_flag_clr = flag_ack[1];
	assign timer1_flag_clr = flag_ack[2];

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			grant_q <= 4'h0;
			grant_hi_q <= 1'b0;
			act_hi_q <= 1'b0;
			act_lo_q <= 1'b0;
			nest_q <= 2'b00;
			push_req <= 1'b0;
			push_pc <= 16'h0000;
			pop_req <= 1'b0;
			pc_load <= 1'b0;
			pc_value <= 16'h0000;
			flag_ack <= 9'h000;
		end else begin
			pc_load <= 1'b0;
			flag_ack <= 9'h000;
			case (state_q)
			S_IDLE: begin
				if (return_from_irq_instr && (act_hi_q || act_lo_q)) begin
					pop_req <= 1'b1;
					state_q <= S_POP;
				end else if (win_ok && instr_done) begin
					// take only at an instruction boundary
					grant_q <= win_idx;
					grant_hi_q <= src_lvl[win_idx];
					push_req <= 1'b1;
					push_pc <= core_pc;
					flag_ack[win_idx] <= 1'b1;
					state_q <= S_PUSH;
				end
			end
			S_PUSH: begin
				if (stack_done) begin
					push_req <= 1'b0;
					state_q <= S_LOAD;
				end
			end
			S_LOAD: begin
				pc_load <= 1'b1;
				pc_value <= vec_of(grant_q);
				if (grant_hi_q) begin
					act_hi_q <= 1'b1;
				end else begin
					act_lo_q <= 1'b1;
				end
				nest_q <= {nest_q[0], grant_hi_q};
				state_q <= S_IDLE;
			end
			S_POP: begin
				if (stack_done) begin
					pop_req <= 1'b0;
					pc_load <= 1'b1;
					pc_value <= pop_pc;
					// the innermost routine's level is released
					if (nest_q[0]) begin
						act_hi_q <= 1'b0;
					end else begin
						act_lo_q <= 1'b0;
					end
					nest_q <= {1'b0, nest_q[1]};
					state_q <= S_HOLD;
				end
			end
			S_HOLD: begin
				// one main-program instruction must finish first
				if (instr_done) begin
					state_q <= S_IDLE;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

// [dv/tlic_assertions.sv]
// checker of the controller's vectoring and register answers
module tlic_checker (
	input logic clock, rst, reg_rd, instr_done, return_from_irq_instr,
	input logic stack_done, push_req, pop_req, pc_load, timer0_flag_clr, timer1_flag_clr,
	input logic [15:0] core_pc, pop_pc, push_pc, pc_value,
	input logic [7:0] reg_rdata,
	input logic [8:0] flag_ack
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// set by a finished pop, cleared by the next finished instruction
	logic hold_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hold_q <= 1'b0;
		end else if (pop_req && stack_done) begin
			hold_q <= 1'b1;
		end else if (instr_done) begin
			hold_q <= 1'b0;
		end
	end
	a_gap_before_grant: assert property ($rose(push_req) |-> !$past(hold_q))
		else $error("grant without one main instruction after return");
	a_push_saves_pc: assert property ($rose(push_req) |-> push_pc == $past(core_pc))
		else $error("return address not the current pc");
	a_push_after_instr: assert property ($rose(push_req) |-> $past(instr_done) && $onehot(flag_ack))
		else $error("push without finished instruction or single ack");
	a_flag_clear_copy: assert property (timer0_flag_clr == flag_ack[1] && timer1_flag_clr == flag_ack[2])
		else $error("timer flag clear not on its response");
	a_vector_after_push: assert property (push_req && stack_done |=> !push_req ##1 pc_load)
		else $error("vector not loaded after push");
	a_pop_restores: assert property (pop_req && stack_done |=> !pop_req && pc_load && pc_value == $past(pop_pc))
		else $error("popped pc not restored");
	a_pop_on_return: assert property ($rose(pop_req) |-> $past(return_from_irq_instr))
		else $error("pop without return");
	a_one_instr_gap: assert property (pop_req && stack_done |=> !push_req [*2])
		else $error("grant before one more instruction");
	a_read_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_stack_exclusive: assert property (!(push_req && pop_req))
		else $error("push and pop together");
endmodule
bind tlic_core tlic_checker chk_i (.*);

// [dv/tlic_cpu_model.sv]
// core and stack model facing the vectoring handshake
module tlic_cpu_model (
	input logic clock, rst, push_req, pop_req, pc_load, fast,
	input logic [15:0] push_pc, pc_value,
	input logic [1:0] lat, // stack wait states
	output logic instr_done, stack_done,
	output logic [15:0] core_pc, pop_pc
);
	logic [15:0] stk [0:3];
	logic [1:0] sp, w;
	// outside its done cycle the popped value is garbage, never the last one
	assign pop_pc = stack_done ? stk[sp - 2'h1] : ~stk[sp - 2'h1];
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			{instr_done, stack_done, sp, w, core_pc} <= '0;
		end else begin
			instr_done <= !(push_req | pop_req) && (fast || $urandom_range(1));
			stack_done <= 1'b0;
			if ((push_req | pop_req) && !stack_done) begin
				w <= w + 2'h1;
				if (w >= lat) begin
					stack_done <= 1'b1;
					w <= '0;
				end
			end
			if (stack_done && push_req) begin
				stk[sp] <= push_pc;
				sp <= sp + 2'h1;
			end
			if (stack_done && pop_req)
				sp <= sp - 2'h1;
			if (pc_load)
				core_pc <= pc_value;
			else if (instr_done)
				core_pc <= core_pc + 16'h1;
		end
	end
endmodule

// [dv/tlic_core_test.sv]
// self-checking bench of the two-level interrupt controller
module tlic_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, reg_wr, reg_rd, ret, fast, push_req, pop_req, pc_load, instr_done;
	logic stack_done, t0c, t1c, wake;
	logic [7:0] addr, wdata, rdata, rv, d;
	logic [8:0] fl, ack, p, lv;
	logic [15:0] core_pc, pop_pc, push_pc, pc_value;
	logic [1:0] lat;
	int miscompares, n_checks, k, e;
	int dp = 0;
	logic [15:0] sv[4];
	int q[9] = '{0, 1, 3, 4, 5, 6, 8, 9, 10};
	logic [7:0] ra[5] = '{8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hc0};
	logic [7:0] rm[5] = '{8'hfb, 8'h0e, 8'h7b, 8'h0e, 8'h00};
	tlic_core uut (.clock, .rst, .reg_addr(addr), .reg_wdata(wdata), .reg_wr, .reg_rd,
		.reg_rdata(rdata), .ext_group0(fl[0]), .timer0_overflow_flag(fl[1]),
		.timer1_overflow_flag(fl[2]), .serial_flag(fl[3]), .timer2_flag(fl[4]),
		.converter_flag(fl[5]), .pwm_flag(fl[6]), .base_timer_flag(fl[7]), .ext_group2(fl[8]),
		.instr_done, .return_from_irq_instr(ret), .core_pc, .stack_done, .pop_pc, .push_req,
		.push_pc, .pop_req, .pc_load, .pc_value, .flag_ack(ack), .timer0_flag_clr(t0c),
		.timer1_flag_clr(t1c), .stop_wake(wake));
	tlic_cpu_model cpu (.clock, .rst, .push_req, .pop_req, .pc_load, .fast, .push_pc,
		.pc_value, .lat, .instr_done, .stack_done, .core_pc, .pop_pc);
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	task chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// register bus and routine helpers
	// ----------------------------------------
	task wr(logic [7:0] a, logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(logic [7:0] a);
		@(posedge clock);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rv = rdata;
	endtask
	function automatic logic [15:0] img(logic [8:0] m);
		img = '0;
		for (int i = 0; i < 9; i++)
			if (m[i]) img[q[i] < 8 ? q[i] : q[i] + 1] = 1'b1;
	endfunction
	// winner: lowest query number among the high pending, else among all
	function automatic int nx(logic [8:0] pm, logic [8:0] lm);
		if ((pm & lm) != 0) pm = pm & lm;
		for (int i = 8; i >= 0; i--)
			if (pm[i]) nx = i;
	endfunction
	task automatic cfg(logic g, logic [8:0] en, logic [8:0] lvl);
		logic [15:0] a = img(en);
		logic [15:0] b = img(lvl);
		wr(8'ha8, {g, a[6:0]});
		wr(8'ha9, a[15:8]);
		wr(8'hb8, b[7:0]);
		wr(8'hb9, b[15:8]);
	endtask
	task serve(int x);
		k = 0;
		do @(negedge clock); while (ack === 9'h0 && ++k < 300);
		chk("ack", ack, 16'h1 << x);
		chk("timer0 clear", t0c, x == 1);
		chk("timer1 clear", t1c, x == 2);
		// the granting edge also counted the finished instruction
		sv[dp] = core_pc - 16'h1;
		dp++;
		if (k >= 300) begin
			miscompares++;
			test_done;
		end
		@(posedge clock);
		fl[x] <= 1'b0;
		do @(negedge clock); while (!pc_load && ++k < 600);
		chk("vector", pc_value, 16'(8 * q[x] + 3));
		if (k >= 600) begin
			miscompares++;
			test_done;
		end
		@(posedge clock);
	endtask
	task rti;
		@(posedge clock);
		ret <= 1'b1;
		@(posedge clock);
		ret <= 1'b0;
		k = 0;
		dp--;
		do @(negedge clock); while (!pc_load && ++k < 300);
		chk("resume", pc_load, 1'b1);
		chk("resume pc", pc_value, sv[dp]);
		if (k >= 300) begin
			miscompares++;
			test_done;
		end
	endtask
	task quiet;
		k = 0;
		do @(negedge clock); while (ack === 9'h0 && ++k < 30);
		chk("blocked", ack, 16'h0);
	endtask
	initial begin
		{rst, reg_wr, reg_rd, ret, fl, addr, wdata, lat} = '0;
		rst = 1'b1;
		fast = 1'b1;
		void'($urandom(5));
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i]);
			chk("reset", rv, 16'h0);
			d = 8'($urandom);
			wr(ra[i], d);
			rd(ra[i]);
			chk("readback", rv, d & rm[i]);
		end
		for (int i = 0; i < 9; i++) begin
			lat <= 2'($urandom);
			fast <= 1'($urandom);
			cfg(1'b1, 9'h1 << i, 9'($urandom));
			fl[i] <= 1'b1;
			@(negedge clock);
			chk("wake", wake, i == 0 || i == 8);
			serve(i);
			rti;
		end
		repeat (4) begin
			p = 9'($urandom);
			lv = 9'($urandom);
			cfg(1'b1, 9'h1ff, lv);
			fl <= p;
			while (p != 0) begin
				e = nx(p, lv);
				serve(e);
				p[e] = 1'b0;
				rti;
			end
		end
		cfg(1'b1, 9'h1ff, 9'h001);
		fl <= 9'h100;
		serve(8);
		fl <= 9'h003;
		serve(0);
		rti;
		quiet;
		rti;
		serve(1);
		rti;
		cfg(1'b1, 9'h0, 9'h0);
		fl <= 9'h001;
		quiet;
		wr(8'ha8, 8'h01);
		quiet;
		wr(8'ha8, 8'h81);
		serve(0);
		rti;
		test_done;
	end
endmodule
